/* bench/hpp_host.sv */
// host processor model for the parallel port pins
`timescale 1ns/100ps
`default_nettype none
module hpp_host (
   input  wire        sys_clk,
   input  wire  [7:0] dout,
   input  wire        oe,
   output logic       sep,
   output logic       cs_n,
   output logic       stb_n,
   output logic       dir_n,
   output logic [4:0] addr,
   output logic [7:0] din
);
   initial {sep, cs_n, stb_n, dir_n, addr, din} = {4'hf, 5'h00, 8'h00};
   // long holds so the two-flop input synchronisers never miss a phase
   task automatic acc(input logic s, w, input logic [4:0] a, input logic [7:0] d,
                      input logic c, output logic [7:0] q);
      @(negedge sys_clk);
      {sep, cs_n, addr, din} = {s, c, a, w ? d : ~din};
      {stb_n, dir_n} = {s & w, ~w};
      repeat (6) @(negedge sys_clk);
      q = (oe === 1'b1) ? dout : ~din; // a released bus reads inverted, never stale
      {stb_n, dir_n, din} = {2'b11, ~din};
      repeat (6) @(negedge sys_clk);
      cs_n = 1'b1;
      repeat (3) @(negedge sys_clk);
   endtask
endmodule
`default_nettype wire

/* bench/hpp_port_sva.sv */
// pin-level assertions for the parallel host port
`timescale 1ns/100ps
`default_nettype none
module hpp_port_chk (
   input wire       sys_clk,
   input wire       reset_n,
   input wire       chip_select_n,
   input wire       shared_access_strobe_n,
   input wire       dir_write_n,
   input wire [7:0] host_data_bus_out,
   input wire       host_data_bus_oe,
   input wire       irq_pending,
   input wire       irq_n_out,
   input wire       irq_n_oe,
   input wire       device_reset_q,
   input wire       reg_wr_pulse_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   chk_irq_level: assert property (irq_n_oe == irq_pending && !irq_n_out)
      else $error("irq pin off request");
   chk_idle_float: assert property (chip_select_n [*4] |=> !host_data_bus_oe)
      else $error("bus driven while idle");
   chk_idle_nowr: assert property (chip_select_n [*6] |=> !reg_wr_pulse_q)
      else $error("write while idle");
   chk_wr_single: assert property (reg_wr_pulse_q |=> !reg_wr_pulse_q)
      else $error("write pulse too long");
   chk_oe_cause: assert property (host_data_bus_oe |-> !$past(shared_access_strobe_n, 3)
      && !$past(chip_select_n, 3) && $past(dir_write_n, 3))
      else $error("bus driven without read");
   chk_rd_zero: assert property (!host_data_bus_oe |-> host_data_bus_out == 8'h00)
      else $error("read data not cleared");
   chk_wr_cause: assert property (reg_wr_pulse_q |-> !$past(chip_select_n, 6)
      && !$past(dir_write_n, 6))
      else $error("write without qualifier");
   chk_rst_long: assert property (disable iff (1'b0) $rose(device_reset_q)
      |-> !$past(reset_n, 25) && !$past(reset_n, 1))
      else $error("device reset too early");
   chk_rst_float: assert property (disable iff (1'b0) !reset_n |=> !host_data_bus_oe)
      else $error("bus driven in reset");
endmodule
bind hpp_port hpp_port_chk u_chk (.*);
`default_nettype wire

/* bench/test_hpp_port.sv */
// self-checking bench for the parallel host port
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_fail++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module test_hpp_port;
   logic       sys_clk = 0, reset_n = 0, irq_pending = 0, clk_en = 1;
   logic       sep, cs_n, stb_n, dir_n, oe, irq_out, irq_oe, rst_q, pulse;
   logic [4:0] addr, wa;
   logic [7:0] din, dout, wd, q;
   int         n_fail = 0, compares = 0, cyc = 0, npulse = 0, n0;
   wire        irq_pin = irq_oe ? irq_out : 1'b1;
   initial forever #20 sys_clk = ~sys_clk;
   hpp_host u_host (.sys_clk(sys_clk), .dout(dout), .oe(oe), .sep(sep), .cs_n(cs_n),
      .stb_n(stb_n), .dir_n(dir_n), .addr(addr), .din(din));
   hpp_port DUT (.sys_clk(sys_clk), .clk_en(clk_en), .reset_n(reset_n),
      .bus_style_select(sep), .chip_select_n(cs_n), .shared_access_strobe_n(stb_n),
      .dir_write_n(dir_n), .host_address_lines(addr), .host_data_bus_in(din),
      .host_data_bus_out(dout), .host_data_bus_oe(oe), .irq_pending(irq_pending),
      .irq_n_out(irq_out), .irq_n_oe(irq_oe), .device_reset_q(rst_q),
      .reg_wr_data_q(wd), .reg_wr_addr_q(wa), .reg_wr_pulse_q(pulse));
   always @(posedge sys_clk)
   begin
      npulse += (pulse === 1'b1);
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         test_done;
      end
   end
   task automatic test_done;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic t_styles;
      n0 = npulse;
      u_host.acc(1, 1, 5'h1f, 8'ha5, 0, q);
      `CHK("wr pulse", n0 + 1, npulse)
      `CHK("wr addr", 5'h1f, wa)
      `CHK("wr data", 8'ha5, wd)
      u_host.acc(0, 1, 5'h01, 8'h3c, 0, q);
      u_host.acc(0, 0, 5'h01, 8'h00, 0, q);
      `CHK("dir rd", 8'h3c, q)
      u_host.acc(1, 0, 5'h1f, 8'h00, 0, q);
      `CHK("sep rd", 8'ha5, q)
      `CHK("rd nowr", n0 + 2, npulse)
   endtask
   task automatic t_idle;
      n0 = npulse;
      u_host.acc(1, 1, 5'h1f, 8'h00, 1, q);
      u_host.acc(0, 0, 5'h1f, 8'h00, 1, q);
      `CHK("idle rd", 8'hff, q)
      `CHK("idle wr", n0, npulse)
      // a write while the clock enable is low must not land; the later read of 1f shows a5
      clk_en = 1'b0;
      u_host.acc(1, 1, 5'h1f, 8'h00, 0, q);
      clk_en = 1'b1;
      `CHK("frozen wr", n0, npulse)
      irq_pending = 1'b1;
      @(negedge sys_clk);
      `CHK("irq on", 1'b0, irq_pin)
      irq_pending = 1'b0;
      @(negedge sys_clk);
      `CHK("irq off", 1'b1, irq_pin)
   endtask
   task automatic t_reset;
      // a short low is filtered, the long one clears the array
      reset_n = 1'b0;
      repeat (10) @(negedge sys_clk);
      reset_n = 1'b1;
      u_host.acc(1, 0, 5'h1f, 8'h00, 0, q);
      `CHK("short rst", 8'ha5, q)
      reset_n = 1'b0;
      repeat (32) @(negedge sys_clk);
      `CHK("dev rst", 1'b1, rst_q)
      reset_n = 1'b1;
      u_host.acc(1, 0, 5'h1f, 8'h00, 0, q);
      `CHK("long rst", 8'h00, q)
   endtask
   initial
   begin
      repeat (3) @(negedge sys_clk);
      reset_n = 1'b1;
      t_styles;
      t_idle;
      t_reset;
      test_done;
   end
endmodule
`default_nettype wire

/* rtl/hpp_map.vh */
// constants for the parallel host port block
`ifndef HPP_MAP_VH
`define HPP_MAP_VH
`define HPP_DATA_W        8
`define HPP_ADDR_W        5
`define HPP_NUM_REGS      32
`define HPP_REG_RESET     8'h00
`define HPP_CLK_NS        40
`define HPP_RESET_MIN_NS  1000
`define HPP_RESET_CYCLES  ((`HPP_RESET_MIN_NS + `HPP_CLK_NS - 1) / `HPP_CLK_NS)
`define HPP_RST_CNT_W     5
`endif

/* rtl/hpp_port.v */
// parallel host port: decodes host strobes, holds the register array, drives irq
// Operation
// - bus_style_select high picks separate read/write strobes, low picks strobe plus direction.
// - in direction style the shared strobe is an active-low data strobe framing each access.
// - in separate style the shared strobe is an active-low read strobe that enables read data.
// - in direction style a high direction line is a host read and the device drives the bus.
// - in direction style a low direction line is a host write and the device stores the bus.
// - in separate style the direction line is an active-low write strobe, bus is input.
// - the port responds only while chip select is low for the whole access.
// - with chip select high the port is idle and all bus pins are released.
// - the data bus is eight bits, bit zero least significant.
// - five address lines select the register, line zero least significant.
// - a low reset held for at least one microsecond resets the whole device; here it needs reset low on 28 rising edges, over 1080 ns.
// - the open-drain interrupt output is pulled low while a request is pending.
// - the interrupt output works regardless of chip select.
`timescale 1ns/100ps
`default_nettype none
`include "hpp_map.vh"
module hpp_port (
   input  wire                     sys_clk,
   input  wire                     clk_en,
   input  wire                     reset_n,
   input  wire                     bus_style_select,
   input  wire                     chip_select_n,
   input  wire                     shared_access_strobe_n,
   input  wire                     dir_write_n,
   input  wire [`HPP_ADDR_W-1:0]   host_address_lines,
   input  wire [`HPP_DATA_W-1:0]   host_data_bus_in,
   output reg  [`HPP_DATA_W-1:0]   host_data_bus_out,
   output reg                      host_data_bus_oe,
   input  wire                     irq_pending,
   output wire                     irq_n_out,
   output wire                     irq_n_oe,
   output reg                      device_reset_q,
   output reg  [`HPP_DATA_W-1:0]   reg_wr_data_q,
   output reg  [`HPP_ADDR_W-1:0]   reg_wr_addr_q,
   output reg                      reg_wr_pulse_q
);
   // ==========================================================
   // pin synchronisers
   // ==========================================================
   localparam SW = 4 + `HPP_ADDR_W + `HPP_DATA_W;
   wire [SW-1:0] pins_sync;
   wire          style_sep;
   wire          cs_n_s;
   wire          strobe_n_s;
   wire          dir_s;
   wire [`HPP_ADDR_W-1:0] addr_s;
   wire [`HPP_DATA_W-1:0] data_s;

   // active-low controls pass inverted, so a cleared synchroniser reads as an idle bus
   hpp_sync #(
      .W (SW)
   ) u_sync (
      .sys_clk  (sys_clk),
      .clk_en   (clk_en),
      .reset_n  (reset_n),
      .async_in ({bus_style_select, ~chip_select_n, ~shared_access_strobe_n, ~dir_write_n,
                  host_address_lines, host_data_bus_in}),
      .sync_q   (pins_sync)
   );
   assign style_sep  = pins_sync[SW-1];
   assign cs_n_s     = ~pins_sync[SW-2];
   assign strobe_n_s = ~pins_sync[SW-3];
   assign dir_s      = ~pins_sync[SW-4];
   assign addr_s     = pins_sync[`HPP_ADDR_W+`HPP_DATA_W-1:`HPP_DATA_W];
   assign data_s     = pins_sync[`HPP_DATA_W-1:0];

   // ==========================================================
   // access decode
   // ==========================================================
   // returns {read_active, write_qualifier} for the chosen bus style
   function [1:0] hpp_decode;
      input sep;
      input cs_n;
      input stb_n;
      input dir;
      begin
         if (cs_n)
            hpp_decode = 2'b00;
         else if (sep)
            hpp_decode = {~stb_n & dir, ~dir};
         else
            hpp_decode = {~stb_n & dir, ~stb_n & ~dir};
      end
   endfunction

   wire [1:0] acc = hpp_decode(style_sep, cs_n_s, strobe_n_s, dir_s);
   wire       rd_act = acc[1];
   wire       wr_act = acc[0];

   // ==========================================================
   // reset width filter
   // ==========================================================
   // a reset pulse shorter than the minimum width does not clear the register array or set the device reset flag
   localparam integer RST_CYC_I = `HPP_RESET_CYCLES;
   localparam [`HPP_RST_CNT_W-1:0] RST_CYC = RST_CYC_I[`HPP_RST_CNT_W-1:0];
   reg [`HPP_RST_CNT_W-1:0] rst_cnt_q;
   reg                      rst_n_s1_q;
   reg                      rst_n_s2_q;
   always @(posedge sys_clk)
   begin
      rst_n_s1_q <= reset_n;
      rst_n_s2_q <= rst_n_s1_q;
      if (rst_n_s2_q)
         rst_cnt_q <= {`HPP_RST_CNT_W{1'b0}};
      else if (rst_cnt_q != RST_CYC)
         rst_cnt_q <= rst_cnt_q + 1'b1;
   end
   wire rst_long = (rst_cnt_q == RST_CYC);

   // ==========================================================
   // write capture
   // ==========================================================
   reg                   wr_prev_q;
   reg [`HPP_ADDR_W-1:0] wr_addr_hold_q;
   reg [`HPP_DATA_W-1:0] wr_data_hold_q;
   wire                  wr_commit;

   // the qualifier ends by its own strobe rising or by chip select rising
   assign wr_commit = wr_prev_q & ~wr_act;

   // sample while the qualifier is held, so the last stable sample is stored
   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         wr_prev_q      <= 1'b0;
         wr_addr_hold_q <= {`HPP_ADDR_W{1'b0}};
         wr_data_hold_q <= `HPP_REG_RESET;
      end
      else if (clk_en)
      begin
         wr_prev_q <= wr_act;
         if (wr_act)
         begin
            wr_addr_hold_q <= addr_s;
            wr_data_hold_q <= data_s;
         end
      end
   end

   // ==========================================================
   // write report to the device core
   // ==========================================================
   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         reg_wr_pulse_q <= 1'b0;
         reg_wr_addr_q  <= {`HPP_ADDR_W{1'b0}};
         reg_wr_data_q  <= `HPP_REG_RESET;
      end
      else if (clk_en)
      begin
         reg_wr_pulse_q <= wr_commit;
         if (wr_commit)
         begin
            reg_wr_addr_q <= wr_addr_hold_q;
            reg_wr_data_q <= wr_data_hold_q;
         end
      end
   end

   // ==========================================================
   // register array
   // ==========================================================
   // only a reset held past the minimum width clears the array, so a glitch
   // on the reset pin leaves the stored setup intact
   reg [`HPP_DATA_W-1:0] regs [0:`HPP_NUM_REGS-1];
   integer i;

   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         if (rst_long)
         begin
            for (i = 0; i < `HPP_NUM_REGS; i = i + 1)
               regs[i] <= `HPP_REG_RESET;
         end
      end
      else if (clk_en && wr_commit)
         regs[wr_addr_hold_q] <= wr_data_hold_q;
   end

   // ==========================================================
   // device reset flag
   // ==========================================================
   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         if (rst_long)
            device_reset_q <= 1'b1;
      end
      else if (clk_en)
         device_reset_q <= 1'b0;
   end

   // ==========================================================
   // read data drive
   // ==========================================================
   // data is zero whenever the bus is released, so no stale byte reaches the pins
   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         host_data_bus_oe  <= 1'b0;
         host_data_bus_out <= `HPP_REG_RESET;
      end
      else if (clk_en)
      begin
         host_data_bus_oe  <= rd_act;
         host_data_bus_out <= rd_act ? regs[addr_s] : `HPP_REG_RESET;
      end
   end

   // ==========================================================
   // interrupt pin
   // ==========================================================
   // open drain: only ever drives low, independent of chip select
   assign irq_n_out = 1'b0;
   assign irq_n_oe  = irq_pending;
endmodule
`default_nettype wire

/* rtl/hpp_sync.v */
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none
module hpp_sync #(
   parameter W = 1
) (
   input  wire         sys_clk,
   input  wire         clk_en,
   input  wire         reset_n,
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_q
);
   reg [W-1:0] meta_q;
   // the first stage feeds only the second stage
   always @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end
      else if (clk_en)
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
endmodule
`default_nettype wire
